// *** design/power_cfg_pkg.sv ***
// package with register addresses, field positions and reset values of the power configuration bank
// Notes on behaviour
// - limit field bits 2:0; 000 shallow, 001 second-level
// - 010/011 C6 variants, 100 C7, 101 C7s
// - limit 111 means no package depth limit
// - no encoding caps the package at C3
// - bit 10 redirects capture-port reads to wait
// - bit 15 locks bits 15:0 until reset
// - bit 25 allows demoting C6/C7 to C3
// - bit 26 allows demoting C3/C6/C7 to C1
// - bit 27 allows undemotion from demoted C3
// - bit 28 allows undemotion from demoted C1
// - nominal ratio read-only in bits 7:0
// - level one power 14:0, ratio 23:16
// - level one max 46:32, min 62:48
// - level two power 14:0, ratio 23:16
// - level two max 46:32, min 62:48
// - level one register ignores all writes
// - level select bits 1:0 writable by firmware
// - control bit 31 freezes whole register until reset
package power_cfg_pkg;
   // register addresses
   localparam logic [31:0] ADDR_IDLE_CONFIG    = 32'h0000_00E2;
   localparam logic [31:0] ADDR_NOMINAL        = 32'h0000_0648;
   localparam logic [31:0] ADDR_LEVEL_ONE      = 32'h0000_0649;
   localparam logic [31:0] ADDR_LEVEL_TWO      = 32'h0000_064A;
   localparam logic [31:0] ADDR_LEVEL_CONTROL  = 32'h0000_064B;
   // idle configuration fields
   localparam int          LIMIT_LSB           = 0;
   localparam int          LIMIT_MSB           = 2;
   localparam int          REDIRECT_BIT        = 10;
   localparam int          CFG_LOCK_BIT        = 15;
   localparam int          DEMOTE_C3_BIT       = 25;
   localparam int          DEMOTE_C1_BIT       = 26;
   localparam int          UNDEMOTE_C3_BIT     = 27;
   localparam int          UNDEMOTE_C1_BIT     = 28;
   localparam logic [63:0] IDLE_WRITE_MASK     = 64'h0000_0000_1E00_8407;
   localparam logic [63:0] IDLE_LOW_MASK       = 64'h0000_0000_0000_FFFF;
   // limit encodings
   localparam logic [2:0]  LIMIT_C0_C1         = 3'h0;
   localparam logic [2:0]  LIMIT_C2            = 3'h1;
   localparam logic [2:0]  LIMIT_C6_NORET      = 3'h2;
   localparam logic [2:0]  LIMIT_C6_RET        = 3'h3;
   localparam logic [2:0]  LIMIT_C7            = 3'h4;
   localparam logic [2:0]  LIMIT_C7S           = 3'h5;
   localparam logic [2:0]  LIMIT_NONE          = 3'h7;
   // control register fields
   localparam int          LEVEL_SEL_MSB       = 1;
   localparam int          LEVEL_LOCK_BIT      = 31;
   localparam logic [1:0]  LEVEL_SEL_RESET     = 2'h0;
   // level descriptor field positions
   localparam int          POWER_LSB           = 0;
   localparam int          RATIO_LSB           = 16;
   localparam int          MAX_POWER_LSB       = 32;
   localparam int          MIN_POWER_LSB       = 48;
   // package depth as one-hot allowance
   typedef enum logic [5:0] {
      DEPTH_C1  = 6'h01,
      DEPTH_C2  = 6'h02,
      DEPTH_C6N = 6'h04,
      DEPTH_C6R = 6'h08,
      DEPTH_C7  = 6'h10,
      DEPTH_ANY = 6'h20
   } depth_t;
endpackage : power_cfg_pkg

// *** design/power_cfg_regs.sv ***
// register bank for package idle configuration and configurable power levels
module power_cfg_regs
   import power_cfg_pkg::*;
#(
   parameter logic [2:0]  LIMIT_DEFAULT = 3'h7,
   parameter logic [7:0]  NOMINAL_RATIO = 8'h10,
   parameter logic [14:0] L1_POWER      = 15'h0100,
   parameter logic [7:0]  L1_RATIO      = 8'h0C,
   parameter logic [14:0] L1_MAX_POWER  = 15'h0180,
   parameter logic [14:0] L1_MIN_POWER  = 15'h0080,
   parameter logic [14:0] L2_POWER      = 15'h00C0,
   parameter logic [7:0]  L2_RATIO      = 8'h08,
   parameter logic [14:0] L2_MAX_POWER  = 15'h0100,
   parameter logic [14:0] L2_MIN_POWER  = 15'h0040
) (
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // register access
   input  wire logic [31:0] addr_i,
   input  wire logic        wr_en_i,
   input  wire logic [63:0] wr_data_i,
   input  wire logic        rd_en_i,
   output logic      [63:0] rd_data_o,
   output logic             rd_valid_o,
   output logic             rd_error_o,
   // settings to the power manager
   output logic      [2:0]  pkg_limit_o,
   output logic      [5:0]  pkg_depth_o,
   output logic             io_redirect_o,
   output logic             demote_c3_en_o,
   output logic             demote_c1_en_o,
   output logic             undemote_c3_en_o,
   output logic             undemote_c1_en_o,
   output logic      [1:0]  power_level_select_o,
   output logic             idle_locked_o,
   output logic             level_locked_o
);

   logic [63:0] idle_reg;
   logic [63:0] idle_next;
   logic [1:0]  level_sel_reg;
   logic        level_lock_reg;
   logic [63:0] nominal_val;
   logic [63:0] level_one_val;
   logic [63:0] level_two_val;
   logic [63:0] control_val;
   logic [63:0] rd_next;
   logic        hit;
   logic        cfg_locked;
   depth_t      depth;

   assign cfg_locked = idle_reg[CFG_LOCK_BIT];

   // next idle value: bits 15:0 frozen once locked, reserved bits dropped
   always_comb begin
      idle_next = wr_data_i & IDLE_WRITE_MASK;
      if (cfg_locked) begin
         idle_next = (idle_next & ~IDLE_LOW_MASK) | (idle_reg & IDLE_LOW_MASK);
      end
   end

   // idle configuration register; lock clears only on reset
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         idle_reg <= {61'h0, LIMIT_DEFAULT};
      end else if (wr_en_i && addr_i == ADDR_IDLE_CONFIG) begin
         idle_reg <= idle_next;
      end
   end

   // level select and its lock; the lock freezes itself too
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         level_sel_reg  <= LEVEL_SEL_RESET;
         level_lock_reg <= 1'b0;
      end else if (wr_en_i && addr_i == ADDR_LEVEL_CONTROL && !level_lock_reg) begin
         level_sel_reg  <= wr_data_i[LEVEL_SEL_MSB:0];
         level_lock_reg <= wr_data_i[LEVEL_LOCK_BIT];
      end
   end

   // read values: descriptors built from constants, control word from its registers, reserved bits zero
   assign nominal_val   = {56'h0, NOMINAL_RATIO};
   assign level_one_val = {1'b0, L1_MIN_POWER, 1'b0, L1_MAX_POWER,
                           8'h0, L1_RATIO, 1'b0, L1_POWER};
   assign level_two_val = {1'b0, L2_MIN_POWER, 1'b0, L2_MAX_POWER,
                           8'h0, L2_RATIO, 1'b0, L2_POWER};
   assign control_val   = {32'h0, level_lock_reg, 29'h0, level_sel_reg};

   // read decode
   always_comb begin
      hit     = 1'b1;
      rd_next = 64'h0;
      unique case (addr_i)
         ADDR_IDLE_CONFIG:   rd_next = idle_reg;
         ADDR_NOMINAL:       rd_next = nominal_val;
         ADDR_LEVEL_ONE:     rd_next = level_one_val;
         ADDR_LEVEL_TWO:     rd_next = level_two_val;
         ADDR_LEVEL_CONTROL: rd_next = control_val;
         default:            hit = 1'b0;
      endcase
   end

   // registered read answer one cycle after the request
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         rd_data_o  <= 64'h0;
         rd_valid_o <= 1'b0;
         rd_error_o <= 1'b0;
      end else begin
         rd_valid_o <= rd_en_i;
         rd_error_o <= rd_en_i && !hit;
         if (rd_en_i) begin
            rd_data_o <= rd_next;
         end
      end
   end

   // decode of the limit field into a one-hot depth allowance
   always_comb begin
      unique case (idle_reg[LIMIT_MSB:LIMIT_LSB])
         LIMIT_C0_C1:    depth = DEPTH_C1;
         LIMIT_C2:       depth = DEPTH_C2;
         LIMIT_C6_NORET: depth = DEPTH_C6N;
         LIMIT_C6_RET:   depth = DEPTH_C6R;
         LIMIT_C7:       depth = DEPTH_C7;
         LIMIT_C7S:      depth = DEPTH_C7;
         LIMIT_NONE:     depth = DEPTH_ANY;
         default:        depth = DEPTH_C1;                       // 110 is not a C3 cap
      endcase
   end

   // settings driven straight from stored bits, except the decoded depth
   assign pkg_limit_o          = idle_reg[LIMIT_MSB:LIMIT_LSB];
   assign pkg_depth_o          = depth;
   assign io_redirect_o        = idle_reg[REDIRECT_BIT];
   assign demote_c3_en_o       = idle_reg[DEMOTE_C3_BIT];
   assign demote_c1_en_o       = idle_reg[DEMOTE_C1_BIT];
   assign undemote_c3_en_o     = idle_reg[UNDEMOTE_C3_BIT];
   assign undemote_c1_en_o     = idle_reg[UNDEMOTE_C1_BIT];
   assign power_level_select_o = level_sel_reg;
   assign idle_locked_o        = cfg_locked;
   assign level_locked_o       = level_lock_reg;

endmodule : power_cfg_regs

// *** testbench/power_cfg_checker.sv ***
// concurrent checks on the power configuration register bank ports
module power_cfg_checker
   import power_cfg_pkg::*;
(
   // clock, reset and access
   input wire logic        clock_i, rst_i, wr_en_i, rd_en_i,
   input wire logic [31:0] addr_i,
   input wire logic [63:0] wr_data_i, rd_data_o,
   // settings
   input wire logic [2:0]  pkg_limit_o,
   input wire logic [5:0]  pkg_depth_o,
   input wire logic [1:0]  power_level_select_o,
   input wire logic        io_redirect_o, demote_c3_en_o, demote_c1_en_o, undemote_c3_en_o, undemote_c1_en_o,
   input wire logic        idle_locked_o, level_locked_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // write strobes per writable register
   wire logic idle_wr = wr_en_i && addr_i == ADDR_IDLE_CONFIG;
   wire logic ctl_wr  = wr_en_i && addr_i == ADDR_LEVEL_CONTROL;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   no_limit_a: assert property (pkg_limit_o == 3'h7 |-> pkg_depth_o == 6'h20) else $error("open depth");
   c6_depth_a: assert property (pkg_limit_o == 3'h2 |-> pkg_depth_o == 6'h04) else $error("c6 depth");
   depth_onehot_a: assert property ($onehot(pkg_depth_o)) else $error("depth not one-hot");
   limit_write_a: assert property (!idle_locked_o && idle_wr |=> pkg_limit_o == $past(wr_data_i[2:0])
      && io_redirect_o == $past(wr_data_i[10])) else $error("idle write lost");
   idle_lock_a: assert property (idle_locked_o && idle_wr |=> $stable(pkg_limit_o) && $stable(io_redirect_o)
      && idle_locked_o) else $error("idle lock broken");
   demote_write_a: assert property (idle_wr |=> {undemote_c1_en_o, undemote_c3_en_o, demote_c1_en_o,
      demote_c3_en_o} == $past(wr_data_i[28:25])) else $error("demote bits lost");
   level_write_a: assert property (!level_locked_o && ctl_wr |=> power_level_select_o == $past(wr_data_i[1:0])
      && level_locked_o == $past(wr_data_i[31])) else $error("control write lost");
   level_lock_a: assert property (level_locked_o && ctl_wr |=> $stable(power_level_select_o) && level_locked_o)
      else $error("control lock broken");
   idle_resv_a: assert property (rd_en_i && addr_i == ADDR_IDLE_CONFIG |=> (rd_data_o & ~IDLE_WRITE_MASK) == 64'h0)
      else $error("reserved bits set");
endmodule : power_cfg_checker
bind power_cfg_regs power_cfg_checker chk (.clock_i(clock_i), .rst_i(rst_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
   .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .pkg_limit_o(pkg_limit_o),
   .pkg_depth_o(pkg_depth_o), .power_level_select_o(power_level_select_o), .io_redirect_o(io_redirect_o),
   .demote_c3_en_o(demote_c3_en_o), .demote_c1_en_o(demote_c1_en_o), .undemote_c3_en_o(undemote_c3_en_o),
   .undemote_c1_en_o(undemote_c1_en_o), .idle_locked_o(idle_locked_o), .level_locked_o(level_locked_o));

// *** testbench/tb_top.sv ***
// self-checking bench for the power configuration register bank
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
   import power_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [14:0] P1 = 15'h1357, X1 = 15'h7FFF, N1 = 15'h0001, P2 = 15'h2468, X2 = 15'h4000, N2 = 15'h7ABC;
   localparam logic [7:0]  NOM = 8'hC3, RA1 = 8'hA5, RA2 = 8'h5A;
   localparam logic [5:0]  DEPTH_TAB [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h10, 6'h01, 6'h20};
   logic        clock_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, rd_valid_o, rd_error_o;
   logic [31:0] addr_i = 32'h0;
   logic [63:0] wr_data_i = 64'h0, rd_data_o, d;
   logic [64:0] exp_q [$], note;
   logic [5:0]  pkg_depth_o;
   integer      seed = 32'h9452, err_total = 0, total_checks = 0, i, n;
   power_cfg_regs #(.LIMIT_DEFAULT(3'h7), .NOMINAL_RATIO(NOM), .L1_POWER(P1), .L1_RATIO(RA1), .L1_MAX_POWER(X1),
      .L1_MIN_POWER(N1), .L2_POWER(P2), .L2_RATIO(RA2), .L2_MAX_POWER(X2), .L2_MIN_POWER(N2)) uut (
      .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
      .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .rd_error_o(rd_error_o),
      .pkg_limit_o(), .pkg_depth_o(pkg_depth_o), .io_redirect_o(), .demote_c3_en_o(), .demote_c1_en_o(),
      .undemote_c3_en_o(), .undemote_c1_en_o(), .power_level_select_o(), .idle_locked_o(), .level_locked_o());
   // packs a level descriptor word
   function automatic logic [63:0] lvl(logic [14:0] p, logic [7:0] r, logic [14:0] mx, logic [14:0] mn);
      lvl = {1'b0, mn, 1'b0, mx, 8'h00, r, 1'b0, p};
   endfunction : lvl
   // one write strobe
   task automatic wr(input logic [31:0] a, input logic [63:0] v);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_en_i <= 1'b1;
      @(posedge clock_i);
      wr_en_i <= 1'b0;
   endtask : wr
   // one read strobe, expected error flag and data noted
   task automatic rd(input logic [31:0] a, input logic [63:0] e, input logic er);
      @(posedge clock_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      exp_q.push_back({er, e});
      @(posedge clock_i);
      rd_en_i <= 1'b0;
   endtask : rd
   task automatic close_out();
      if (err_total == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // clock at 25 MHz
   initial begin
      forever #20 clock_i = ~clock_i;
   end
   // read answers against oldest note
   always @(posedge clock_i) begin
      if (rd_valid_o === 1'b1 && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         `CHK({rd_error_o, rd_data_o}, note)
      end
   end
   initial begin
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      // reset contents, descriptors, unmapped place, then writes to read-only words
      for (n = 0; n < 2; n++) begin
         rd(ADDR_IDLE_CONFIG, 64'h7, 1'b0);
         rd(ADDR_NOMINAL, {56'h0, NOM}, 1'b0);
         rd(ADDR_LEVEL_ONE, lvl(P1, RA1, X1, N1), 1'b0);
         rd(ADDR_LEVEL_TWO, lvl(P2, RA2, X2, N2), 1'b0);
         rd(ADDR_LEVEL_CONTROL, 64'h0, 1'b0);
         rd(32'h0000_0650, 64'h0, 1'b1);
         wr(ADDR_LEVEL_ONE, ~64'h0);
         wr(ADDR_NOMINAL, ~64'h0);
      end
      // every limit code with random upper bits, lock clear
      for (i = 0; i < 8; i++) begin
         d = {$random(seed), $random(seed)} & ~64'h8000;
         d[2:0] = i[2:0];
         wr(ADDR_IDLE_CONFIG, d);
         @(negedge clock_i);
         `CHK(pkg_depth_o, DEPTH_TAB[i])
         rd(ADDR_IDLE_CONFIG, d & IDLE_WRITE_MASK, 1'b0);
      end
      // every level select, lock clear
      for (i = 0; i < 4; i++) begin
         d = {$random(seed), $random(seed)} & ~64'h8000_0000;
         d[1:0] = i[1:0];
         wr(ADDR_LEVEL_CONTROL, d);
         rd(ADDR_LEVEL_CONTROL, {62'h0, i[1:0]}, 1'b0);
      end
      // both locks set, then written again
      wr(ADDR_LEVEL_CONTROL, 64'h8000_0002);
      wr(ADDR_LEVEL_CONTROL, 64'h1);
      rd(ADDR_LEVEL_CONTROL, 64'h8000_0002, 1'b0);
      wr(ADDR_IDLE_CONFIG, 64'h8402);
      wr(ADDR_IDLE_CONFIG, ~64'h0);
      rd(ADDR_IDLE_CONFIG, 64'h1E00_8402, 1'b0);
      // second reset clears the locks
      @(posedge clock_i);
      rst_i <= 1'b1;
      repeat (6) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(ADDR_IDLE_CONFIG, 64'h7, 1'b0);
      rd(ADDR_LEVEL_CONTROL, 64'h0, 1'b0);
      for (n = 0; n < 20 && exp_q.size() > 0; n++) @(posedge clock_i);
      if (exp_q.size() > 0) err_total++;
      close_out();
   end
endmodule : tb_top
